// ==== core/cpc_clock_output_pin_pin.sv ====
`timescale 1ns/100ps
module cpc_clock_output_pin_pin
   import cpc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [1:0] src,
   input wire logic dir,
   input wire logic dout,
   input wire logic iface_clk_lvl,
   input wire logic cpu_clk_lvl,
   input wire logic sys_clk_lvl,
   output logic pin_out,
   output logic pin_oe
);
   // The selected clock levels are retimed, so the pin lags them by one cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_out <= 1'b0;
         pin_oe <= 1'b0;
      end else begin
         unique case (cpc_src_e'(src))
            CPC_SRC_GPIO: begin
               pin_oe <= dir;
               pin_out <= dir & dout;
            end
            CPC_SRC_IFACE: begin
               pin_oe <= 1'b1;
               pin_out <= iface_clk_lvl;
            end
            CPC_SRC_CPU: begin
               pin_oe <= 1'b1;
               pin_out <= cpu_clk_lvl;
            end
            CPC_SRC_SYS: begin
               pin_oe <= 1'b1;
               pin_out <= sys_clk_lvl;
            end
         endcase
      end
   end
endmodule : cpc_clock_output_pin_pin

// ==== core/cpc_pkg.sv ====
package cpc_pkg;
   // Register word offsets on the APB (byte addresses)
   localparam logic [7:0] CPC_OFS_CLOCK_CONTROL = 8'h00;
   localparam logic [7:0] CPC_OFS_GLOBAL_CONTROL = 8'h04;
   localparam logic [7:0] CPC_OFS_NEW_GLOBAL_CONTROL = 8'h08;
   localparam logic [7:0] CPC_OFS_IRQ_STATUS = 8'h0c;
   localparam logic [7:0] CPC_OFS_IRQ_MASK = 8'h10;

   // Clock control field positions
   localparam int unsigned CPC_CC_GATE_BIT = 7;
   localparam int unsigned CPC_CC_SRC_LSB = 5;
   localparam int unsigned CPC_CC_DIR_BIT = 4;
   localparam int unsigned CPC_CC_DOUT_BIT = 3;
   localparam int unsigned CPC_CC_DIN_BIT = 2;
   localparam int unsigned CPC_CC_LP_LSB = 0;
   // Input data bit is never stored
   localparam logic [15:0] CPC_CC_WMASK = 16'h00fb;

   // Global control field positions
   localparam int unsigned CPC_GC_FLASH_BIT = 4;
   localparam int unsigned CPC_GC_PLL_STBY_BIT = 13;
   localparam int unsigned CPC_GC_TIMER_OSC_BIT = 14;
   localparam logic [15:0] CPC_GC_WMASK = 16'hffff;

   // Reset values
   localparam logic [7:0] CPC_CC_RST = 8'h00;
   localparam logic [15:0] CPC_GC_RST = 16'h0000;
   localparam logic [15:0] CPC_NGC_RST = 16'h0000;
   localparam logic [1:0] CPC_IRQ_MASK_RST = 2'b00;

   // Timing
   localparam logic [1:0] CPC_GC_WAIT_STATES = 2'd3;

   // Peripherals and interrupt events
   localparam int unsigned CPC_NUM_PERIPH = 8;
   localparam int unsigned CPC_IRQ_W = 2;
   localparam int unsigned CPC_IRQ_PIN_CHANGE = 0;
   localparam int unsigned CPC_IRQ_FLASH_VIOL = 1;

   typedef enum logic [1:0] {
      CPC_SRC_GPIO = 2'b00,
      CPC_SRC_IFACE = 2'b01,
      CPC_SRC_CPU = 2'b10,
      CPC_SRC_SYS = 2'b11
   } cpc_src_e;

   typedef enum logic [1:0] {
      CPC_LP_RUN = 2'b00,
      CPC_LP_IDLE = 2'b01,
      CPC_LP_STANDBY = 2'b10,
      CPC_LP_HALT = 2'b11
   } cpc_lp_e;

   typedef enum logic [1:0] {
      CPC_ST_IDLE = 2'b00,
      CPC_ST_WAIT = 2'b11,
      CPC_ST_DONE = 2'b01
   } cpc_bus_e;

   // Byte-lane merge of the low half-word, restricted to writable bits
   function automatic logic [15:0] cpc_merge(input logic [15:0] old_v,
                                             input logic [15:0] new_v,
                                             input logic [1:0] strb,
                                             input logic [15:0] wmask);
      logic [15:0] en;
      en = {{8{strb[1]}}, {8{strb[0]}}} & wmask;
      return (old_v & ~en) | (new_v & en);
   endfunction : cpc_merge
endpackage : cpc_pkg

// ==== core/cpc_top.sv ====
// Operation
// - The clock control register takes byte, half-word and word access in any mode, two cycles.
// - Bit 7 of clock control, when set, stops register clocks of powered-down peripherals.
// - A powered-down peripheral loses its logic clock, and its register clock too when gated.
// - Source field 6:5 picks GPIO, interface clock, CPU clock or system clock for the pin.
// - Bit 4 makes the GPIO pin an output when set, an input when clear, only in GPIO mode.
// - Bit 3 is the level driven on the pin in GPIO output mode and is ignored otherwise.
// - Bit 2 reads the present pin level and ignores writes.
// - Field 1:0 selects run, idle, standby or halt and is read/write in any mode.
// - Every write to global control is stretched by three wait states.
// - Global control reads in any mode and changes only on privileged writes.
// - Global control bit 4 opens flash register access; closed, an access is illegal.
// - Global control bit 14 clocks the timer from the oscillator instead of the system clock.
// - Global control bit 13 turns the PLL off while in standby.
`timescale 1ns/100ps
module cpc_top
   import cpc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [2:0] pprot,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [CPC_NUM_PERIPH-1:0] periph_pdn,
   output logic [CPC_NUM_PERIPH-1:0] periph_logic_clk_en,
   output logic [CPC_NUM_PERIPH-1:0] periph_reg_clk_en,
   input wire logic iface_clk_lvl,
   input wire logic cpu_clk_lvl,
   input wire logic sys_clk_lvl,
   input wire logic pin_in,
   output logic pin_out,
   output logic pin_oe,
   output logic [1:0] low_power_mode,
   input wire logic flash_reg_req,
   output logic flash_access_enable,
   output logic flash_illegal_addr,
   output logic timer_osc_select,
   output logic pll_standby_off,
   output logic [15:0] pll_ctrl,
   output logic [15:0] pll_ctrl_new,
   output logic irq
);
   cpc_bus_e st_q;
   logic [1:0] wait_q;
   logic pready_q;
   logic pslverr_q;
   logic [31:0] prdata_q;
   logic [31:0] rdata_d;
   logic [7:0] cc_q;
   logic [15:0] gc_q;
   logic [15:0] ngc_q;
   logic [CPC_IRQ_W-1:0] stat_q;
   logic [CPC_IRQ_W-1:0] stat_set;
   logic [CPC_IRQ_W-1:0] stat_clr;
   logic [CPC_IRQ_W-1:0] mask_q;
   logic irq_q;
   logic pin_in_q;
   logic [CPC_NUM_PERIPH-1:0] logic_en_q;
   logic [CPC_NUM_PERIPH-1:0] reg_en_q;
   logic pll_off_q;
   logic flash_ill_q;
   logic setup;
   logic acc_done;
   logic wr_done;
   logic hit_cc;
   logic hit_gc;
   logic hit_ngc;
   logic hit_stat;
   logic hit_mask;
   logic mapped;
   logic gpio_in_mode;
   logic [15:0] cc_wr_v;

   assign setup = psel & ~penable;
   assign acc_done = psel & penable & pready_q;
   assign wr_done = acc_done & pwrite;
   // Low two address bits are ignored: every register is one aligned word
   assign hit_cc = {paddr[7:2], 2'b00} == CPC_OFS_CLOCK_CONTROL;
   assign hit_gc = {paddr[7:2], 2'b00} == CPC_OFS_GLOBAL_CONTROL;
   assign hit_ngc = {paddr[7:2], 2'b00} == CPC_OFS_NEW_GLOBAL_CONTROL;
   assign hit_stat = {paddr[7:2], 2'b00} == CPC_OFS_IRQ_STATUS;
   assign hit_mask = {paddr[7:2], 2'b00} == CPC_OFS_IRQ_MASK;
   assign mapped = hit_cc | hit_gc | hit_ngc | hit_stat | hit_mask;
   assign gpio_in_mode = (cc_q[CPC_CC_SRC_LSB+:2] == CPC_SRC_GPIO) & ~cc_q[CPC_CC_DIR_BIT];
   // Merged on a net first, since a function result cannot be part-selected
   assign cc_wr_v = cpc_merge({8'h00, cc_q}, pwdata[15:0], pstrb[1:0], CPC_CC_WMASK);

   // Bus handshake: one access cycle normally, three extra for global control writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= CPC_ST_IDLE;
         wait_q <= 2'd0;
         pready_q <= 1'b0;
      end else begin
         unique case (st_q)
            CPC_ST_IDLE: begin
               if (setup) begin
                  if (pwrite && hit_gc) begin
                     st_q <= CPC_ST_WAIT;
                     wait_q <= CPC_GC_WAIT_STATES - 2'd1;
                  end else begin
                     st_q <= CPC_ST_DONE;
                     pready_q <= 1'b1;
                  end
               end
            end
            CPC_ST_WAIT: begin
               if (wait_q == 2'd0) begin
                  st_q <= CPC_ST_DONE;
                  pready_q <= 1'b1;
               end else begin
                  wait_q <= wait_q - 2'd1;
               end
            end
            CPC_ST_DONE: begin
               if (acc_done) begin
                  st_q <= CPC_ST_IDLE;
                  pready_q <= 1'b0;
               end
            end
            default: begin
               st_q <= CPC_ST_IDLE;
               pready_q <= 1'b0;
            end
         endcase
      end
   end

   always_comb begin
      rdata_d = 32'h0000_0000;
      if (hit_cc) begin
         rdata_d[7:0] = cc_q;
         rdata_d[CPC_CC_DIN_BIT] = pin_in_q;
      end else if (hit_gc) begin
         rdata_d[15:0] = gc_q;
      end else if (hit_ngc) begin
         rdata_d[15:0] = ngc_q;
      end else if (hit_stat) begin
         rdata_d[CPC_IRQ_W-1:0] = stat_q;
      end else if (hit_mask) begin
         rdata_d[CPC_IRQ_W-1:0] = mask_q;
      end
   end

   // Read data is captured in the setup cycle so it can come from a flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else if (setup && st_q == CPC_ST_IDLE) begin
         prdata_q <= pwrite ? 32'h0000_0000 : rdata_d;
         pslverr_q <= ~mapped;
      end
   end

   // Clock control: all modes, any lane width; only lane 0 holds bits
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cc_q <= CPC_CC_RST;
      end else if (wr_done && hit_cc) begin
         cc_q <= cc_wr_v[7:0];
      end
   end

   // Global control: user-mode writes are dropped silently
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gc_q <= CPC_GC_RST;
      end else if (wr_done && hit_gc && pprot[0]) begin
         gc_q <= cpc_merge(gc_q, pwdata[15:0], pstrb[1:0], CPC_GC_WMASK);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ngc_q <= CPC_NGC_RST;
      end else if (wr_done && hit_ngc) begin
         ngc_q <= cpc_merge(ngc_q, pwdata[15:0], pstrb[1:0], CPC_GC_WMASK);
      end
   end

   // Events: pin level change while an input, and a refused flash access
   always_comb begin
      stat_set = '0;
      stat_set[CPC_IRQ_PIN_CHANGE] = gpio_in_mode & (pin_in != pin_in_q);
      stat_set[CPC_IRQ_FLASH_VIOL] = flash_reg_req & ~gc_q[CPC_GC_FLASH_BIT];
      stat_clr = (wr_done && hit_stat && pstrb[0]) ? pwdata[CPC_IRQ_W-1:0] : '0;
   end

   // A set in the clearing cycle wins so no event is lost
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat_q <= '0;
      end else begin
         stat_q <= (stat_q & ~stat_clr) | stat_set;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_q <= CPC_IRQ_MASK_RST;
      end else if (wr_done && hit_mask && pstrb[0]) begin
         mask_q <= pwdata[CPC_IRQ_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(stat_q & mask_q);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_in_q <= 1'b0;
      end else begin
         pin_in_q <= pin_in;
      end
   end

   // Clock gating enables; software must drop the gating bit before waking a module
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         logic_en_q <= '1;
         reg_en_q <= '1;
      end else begin
         logic_en_q <= ~periph_pdn;
         reg_en_q <= ~(periph_pdn & {CPC_NUM_PERIPH{cc_q[CPC_CC_GATE_BIT]}});
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pll_off_q <= 1'b0;
         flash_ill_q <= 1'b0;
      end else begin
         pll_off_q <= gc_q[CPC_GC_PLL_STBY_BIT] & (cc_q[1:0] == CPC_LP_STANDBY);
         flash_ill_q <= flash_reg_req & ~gc_q[CPC_GC_FLASH_BIT];
      end
   end

   cpc_clock_output_pin_pin u_pin (
      .pclk(pclk),
      .presetn(presetn),
      .src(cc_q[CPC_CC_SRC_LSB+:2]),
      .dir(cc_q[CPC_CC_DIR_BIT]),
      .dout(cc_q[CPC_CC_DOUT_BIT]),
      .iface_clk_lvl(iface_clk_lvl),
      .cpu_clk_lvl(cpu_clk_lvl),
      .sys_clk_lvl(sys_clk_lvl),
      .pin_out(pin_out),
      .pin_oe(pin_oe)
   );

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign periph_logic_clk_en = logic_en_q;
   assign periph_reg_clk_en = reg_en_q;
   assign low_power_mode = cc_q[CPC_CC_LP_LSB+:2];
   assign flash_access_enable = gc_q[CPC_GC_FLASH_BIT];
   assign flash_illegal_addr = flash_ill_q;
   assign timer_osc_select = gc_q[CPC_GC_TIMER_OSC_BIT];
   assign pll_standby_off = pll_off_q;
   assign pll_ctrl = gc_q;
   assign pll_ctrl_new = ngc_q;
   assign irq = irq_q;

   default clocking cpc_cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   chk_cc_two_cycle: assert property (
      setup && hit_cc && st_q == CPC_ST_IDLE |=> pready_q && penable)
      else $error("clock control access not answered in two cycles");

   chk_gc_wait_states: assert property (
      setup && pwrite && hit_gc && st_q == CPC_ST_IDLE |=> (!pready_q)[*3] ##1 pready_q)
      else $error("global control write not stretched by three waits");

   chk_gc_user_write: assert property (
      wr_done && hit_gc && !pprot[0] |=> $stable(gc_q))
      else $error("user write changed global control");

   chk_reg_clk_gate: assert property (
      ##1 reg_en_q == ~($past(periph_pdn) & {CPC_NUM_PERIPH{$past(cc_q[CPC_CC_GATE_BIT])}}))
      else $error("register clock enable disagrees with gating bit");

   chk_logic_clk_gate: assert property (
      $rose(periph_pdn[0]) |=> !logic_en_q[0] && (reg_en_q[0] == !cc_q[CPC_CC_GATE_BIT]
                                                  || $changed(cc_q)))
      else $error("powered-down peripheral keeps its clock");

   chk_pin_src_clock: assert property (
      cc_q[CPC_CC_SRC_LSB+:2] == CPC_SRC_CPU |=> pin_oe && pin_out == $past(cpu_clk_lvl))
      else $error("pin does not follow selected clock");

   chk_pin_gpio_in: assert property (
      gpio_in_mode |=> !pin_oe)
      else $error("pin driven in input mode");

   chk_pin_gpio_out: assert property (
      cc_q[CPC_CC_SRC_LSB+:2] == CPC_SRC_GPIO && cc_q[CPC_CC_DIR_BIT]
      |=> pin_oe && pin_out == $past(cc_q[CPC_CC_DOUT_BIT]))
      else $error("pin output level does not match data bit");

   chk_pin_readback: assert property (
      acc_done && !pwrite && hit_cc && st_q == CPC_ST_DONE |-> prdata_q[2] == $past(pin_in_q))
      else $error("input data bit does not show the pin level");

   chk_flash_refused: assert property (
      flash_reg_req && !gc_q[CPC_GC_FLASH_BIT] |=> flash_ill_q && stat_q[CPC_IRQ_FLASH_VIOL])
      else $error("flash access while closed not flagged");

   chk_pll_standby: assert property (
      gc_q[CPC_GC_PLL_STBY_BIT] && cc_q[1:0] == CPC_LP_STANDBY && $stable(gc_q) && $stable(cc_q)
      |=> pll_off_q)
      else $error("PLL not turned off in standby");

   chk_irq_level: assert property (
      |(stat_q & mask_q) |=> irq_q)
      else $error("interrupt not raised for unmasked status");
endmodule : cpc_top

// ==== testbench/cpc_top_tb.sv ====
`timescale 1ns/100ps
module cpc_top_tb
   import cpc_pkg::*;
;
   localparam logic [7:0] A_CC = CPC_OFS_CLOCK_CONTROL;
   localparam logic [7:0] A_GC = CPC_OFS_GLOBAL_CONTROL;
   localparam logic [7:0] A_NGC = CPC_OFS_NEW_GLOBAL_CONTROL;
   localparam logic [7:0] A_ST = CPC_OFS_IRQ_STATUS;
   localparam logic [7:0] A_MSK = CPC_OFS_IRQ_MASK;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0] pstrb;
   logic [2:0] pprot;
   logic [7:0] periph_pdn, periph_logic_clk_en, periph_reg_clk_en;
   logic iface_clk_lvl, cpu_clk_lvl, sys_clk_lvl, pin_in, pin_out, pin_oe, ext_lvl;
   logic [1:0] low_power_mode;
   logic flash_reg_req, flash_access_enable, flash_illegal_addr, timer_osc_select;
   logic pll_standby_off, irq;
   logic [15:0] pll_ctrl, pll_ctrl_new;
   int n_errors, cmp_count, nc;
   logic [31:0] rdv;
   logic er;

   // The pin wire: the block wins while it drives, otherwise the outside level
   assign pin_in = pin_oe ? pin_out : ext_lvl;

   cpc_top u_cpc_top (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .pprot(pprot), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .periph_pdn(periph_pdn),
      .periph_logic_clk_en(periph_logic_clk_en), .periph_reg_clk_en(periph_reg_clk_en),
      .iface_clk_lvl(iface_clk_lvl), .cpu_clk_lvl(cpu_clk_lvl), .sys_clk_lvl(sys_clk_lvl),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .low_power_mode(low_power_mode),
      .flash_reg_req(flash_reg_req), .flash_access_enable(flash_access_enable),
      .flash_illegal_addr(flash_illegal_addr), .timer_osc_select(timer_osc_select),
      .pll_standby_off(pll_standby_off), .pll_ctrl(pll_ctrl), .pll_ctrl_new(pll_ctrl_new),
      .irq(irq)
   );

   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   task automatic chk(input string nm, input logic [32:0] got, input logic [32:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
   endtask : tick

   // Entered right after a rising edge; leaves one idle edge so psel never toggles twice
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, input logic [2:0] pr);
      nc = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      pprot <= pr;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         nc++;
      end while (pready !== 1'b1);
      rdv = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [2:0] pr);
      apb(1'b1, a, d, 4'hf, pr);
   endtask : wr

   task automatic rd(input logic [7:0] a);
      apb(1'b0, a, 32'h0, 4'h0, 3'h1);
   endtask : rd

   task automatic t_reset();
      for (int i = 0; i < 5; i++) begin
         rd(8'(i * 4));
         chk("rst_reg", {er, rdv}, 33'h0);
      end
      chk("rst_outs", {pin_oe, irq, flash_access_enable, timer_osc_select}, 33'h0);
      chk("rst_clk_en", {periph_logic_clk_en, periph_reg_clk_en}, 33'hffff);
      $display("t_reset done");
   endtask : t_reset

   task automatic t_cc();
      for (int i = 0; i < 4; i++) begin
         wr(A_CC, 32'h4 | i, 3'h0);
         chk("cc_wr_cycles", nc, 33'd1);
         rd(A_CC);
         chk("cc_rd_cycles", nc, 33'd1);
         chk("cc_lp", rdv, i);
         chk("lp_out", low_power_mode, i);
      end
      // Only lane 1 strobed: the lane 0 data must not land
      apb(1'b1, A_CC, 32'hff, 4'h2, 3'h0);
      rd(A_CC);
      chk("cc_lane", rdv, 33'd3);
      $display("t_cc done");
   endtask : t_cc

   task automatic t_pin();
      wr(A_CC, 32'h0, 3'h1);
      ext_lvl <= 1'b1;
      tick(3);
      chk("oe_in", pin_oe, 33'd0);
      rd(A_CC);
      chk("din_ext", rdv[2], 33'd1);
      // The input-mode level change must have raised the pin event
      rd(A_ST);
      chk("st_pin_event", rdv, 33'd1);
      wr(A_ST, 32'h1, 3'h0);
      rd(A_ST);
      chk("st_pin_clear", rdv, 33'd0);
      for (int d = 0; d < 2; d++) begin
         wr(A_CC, 32'h10 | (d << 3), 3'h1);
         tick(3);
         chk("oe_out", pin_oe, 33'd1);
         chk("dout", pin_out, d);
         rd(A_CC);
         chk("din_drv", rdv[2], d);
      end
      for (int s = 1; s < 4; s++) begin
         wr(A_CC, 32'h8 | (s << 5), 3'h1);
         {sys_clk_lvl, cpu_clk_lvl, iface_clk_lvl} <= 3'b001 << (s - 1);
         tick(3);
         chk("src_hi", {pin_oe, pin_out}, 33'd3);
         {sys_clk_lvl, cpu_clk_lvl, iface_clk_lvl} <= ~(3'b001 << (s - 1));
         tick(3);
         chk("src_lo", {pin_oe, pin_out}, 33'd2);
      end
      wr(A_CC, 32'h0, 3'h1);
      $display("t_pin done");
   endtask : t_pin

   task automatic t_gate();
      periph_pdn <= 8'ha5;
      tick(3);
      chk("lclk", periph_logic_clk_en, 33'h5a);
      chk("rclk_open", periph_reg_clk_en, 33'hff);
      wr(A_CC, 32'h80, 3'h0);
      tick(3);
      chk("lclk_gated", periph_logic_clk_en, 33'h5a);
      chk("rclk_gated", periph_reg_clk_en, 33'h5a);
      wr(A_CC, 32'h0, 3'h0); // Gating off before the power-down bits
      periph_pdn <= 8'h00;
      tick(3);
      chk("wake", {periph_logic_clk_en, periph_reg_clk_en}, 33'hffff);
      $display("t_gate done");
   endtask : t_gate

   task automatic t_gc();
      wr(A_GC, 32'hffff_5a5a, 3'h1);
      chk("gc_wait", nc, 33'd4);
      rd(A_GC);
      chk("gc_rd", rdv, 33'h5a5a);
      wr(A_GC, 32'h0, 3'h0);
      chk("gc_user_wait", nc, 33'd4);
      rd(A_GC);
      chk("gc_user", rdv, 33'h5a5a);
      tick(2);
      chk("gc_outs", {flash_access_enable, timer_osc_select, pll_ctrl}, 33'h35a5a);
      wr(A_NGC, 32'hffff_a5a5, 3'h0);
      chk("ngc_wait", nc, 33'd1);
      rd(A_NGC);
      chk("ngc_rd", rdv, 33'ha5a5);
      tick(2);
      chk("ngc_out", pll_ctrl_new, 33'ha5a5);
      rd(8'h20);
      chk("unmapped", {er, rdv}, 33'h1_0000_0000);
      $display("t_gc done");
   endtask : t_gc

   task automatic t_pll();
      wr(A_GC, 32'h2000, 3'h1);
      for (int i = 0; i < 4; i++) begin
         wr(A_CC, i, 3'h0);
         tick(3);
         chk("pll_off", pll_standby_off, i == 2);
      end
      wr(A_CC, 32'h2, 3'h0);
      wr(A_GC, 32'h0, 3'h1);
      tick(3);
      chk("pll_kept", pll_standby_off, 33'd0);
      wr(A_CC, 32'h0, 3'h0);
      $display("t_pll done");
   endtask : t_pll

   task automatic fl_req(input logic exp);
      flash_reg_req <= 1'b1;
      @(posedge pclk);
      flash_reg_req <= 1'b0;
      @(posedge pclk);
      chk("fl_illegal", flash_illegal_addr, exp);
      @(posedge pclk);
      chk("fl_pulse", flash_illegal_addr, 33'd0);
   endtask : fl_req

   task automatic t_flash();
      wr(A_ST, 32'h3, 3'h0);
      wr(A_MSK, 32'h0, 3'h0);
      fl_req(1'b1);
      chk("irq_masked", irq, 33'd0);
      rd(A_ST);
      chk("st_set", rdv, 33'd2);
      wr(A_MSK, 32'h2, 3'h0);
      tick(2);
      chk("irq_on", irq, 33'd1);
      wr(A_ST, 32'h2, 3'h0);
      tick(2);
      chk("irq_off", irq, 33'd0);
      wr(A_GC, 32'h10, 3'h1);
      fl_req(1'b0);
      rd(A_ST);
      chk("st_clear", rdv, 33'd0);
      $display("t_flash done");
   endtask : t_flash

   task automatic test_done();
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : test_done

   initial begin
      n_errors = 0;
      cmp_count = 0;
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata, pstrb, pprot} = '0;
      periph_pdn = 8'h00;
      {sys_clk_lvl, cpu_clk_lvl, iface_clk_lvl} = 3'b000;
      ext_lvl = 1'b0;
      flash_reg_req = 1'b0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_cc();
      t_pin();
      t_gate();
      t_gc();
      t_pll();
      t_flash();
      test_done();
   end

   // The whole run needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge pclk);
      n_errors++;
      test_done();
   end
endmodule : cpc_top_tb
